/* rtl/sld_top.sv */
// Module: status lamp pattern driver for module, network, link and activity lamps
`timescale 1ns/1ps

module sld_top
   import sld_pkg::*;
#(
   parameter int unsigned TICK_CYC = MS_TICK_CYC
)
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       selftest_run,
   input  wire logic       configured,
   input  wire logic       recov_fault,
   input  wire logic       unrecov_fault,
   input  wire logic       ip_valid,
   input  wire logic       conn_present,
   input  wire logic [7:0] eo_lost,
   input  wire logic       dup_ip,
   input  wire logic [1:0] phy_link,
   input  wire logic [1:0] phy_act,
   output logic            module_health_lamp_grn,
   output logic            module_health_lamp_red,
   output logic            network_health_lamp_grn,
   output logic            network_health_lamp_red,
   output logic [1:0]      link_lamp,
   output logic [1:0]      act_lamp
);

   // ==========================================================
   // Widths
   localparam int unsigned     PRE_W    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

   // ==========================================================
   // State
   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic             tick;
      logic [8:0]       blink_cnt;
      logic             blink;
      sld_st_e          st;
      logic [8:0]       st_cnt;
      logic [1:0]       link_s1;
      logic [1:0]       link_s2;
      logic [1:0]       act_s1;
      logic [1:0]       act_s2;
      logic             mod_grn;
      logic             mod_red;
      logic             net_grn;
      logic             net_red;
      logic [1:0]       link_on;
   } sld_top_s;

   sld_top_s st_r;
   sld_top_s st_nxt;

   sld_pat_e mod_pat;
   sld_pat_e net_pat;
   logic     eo_timeout;

   // ==========================================================
   // Pattern selection
   assign eo_timeout = |eo_lost;

   always_comb begin
      if (selftest_run) begin
         if (st_r.st == ST_RED) begin
            mod_pat = PAT_RED;
         end else begin
            mod_pat = PAT_GRN;
         end
      end else if (unrecov_fault) begin
         mod_pat = PAT_RED;
      end else if (recov_fault) begin
         mod_pat = PAT_RED_FLASH;
      end else if (!configured) begin
         mod_pat = PAT_GRN_FLASH;
      end else begin
         mod_pat = PAT_GRN;
      end
   end

   always_comb begin
      if (selftest_run) begin
         case (st_r.st)
            ST_RED: begin
               net_pat = PAT_RED;
            end
            ST_HOLD: begin
               net_pat = PAT_OFF;
            end
            default: begin
               net_pat = PAT_GRN;
            end
         endcase
      end else if (!ip_valid) begin
         net_pat = PAT_OFF;
      end else if (dup_ip) begin
         net_pat = PAT_RED;
      end else if (eo_timeout) begin
         net_pat = PAT_RED_FLASH;
      end else if (conn_present) begin
         net_pat = PAT_GRN;
      end else begin
         net_pat = PAT_GRN_FLASH;
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;

      // Millisecond prescaler
      if (st_r.pre == PRE_LAST) begin
         st_nxt.pre  = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.pre  = st_r.pre + PRE_W'(1);
         st_nxt.tick = 1'b0;
      end

      // Shared 1 Hz flash phase
      if (st_r.tick) begin
         if (st_r.blink_cnt == FLASH_LAST) begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink     = ~st_r.blink;
         end else begin
            st_nxt.blink_cnt = st_r.blink_cnt + 9'h001;
         end
      end

      // Self-test sequencer
      if (!selftest_run) begin
         st_nxt.st     = ST_IDLE;
         st_nxt.st_cnt = '0;
      end else begin
         case (st_r.st)
            ST_IDLE: begin
               st_nxt.st     = ST_GREEN;
               st_nxt.st_cnt = '0;
            end
            ST_GREEN: begin
               if (st_r.tick) begin
                  if (st_r.st_cnt == STEP_LAST) begin
                     st_nxt.st     = ST_RED;
                     st_nxt.st_cnt = '0;
                  end else begin
                     st_nxt.st_cnt = st_r.st_cnt + 9'h001;
                  end
               end
            end
            ST_RED: begin
               if (st_r.tick) begin
                  if (st_r.st_cnt == STEP_LAST) begin
                     st_nxt.st     = ST_HOLD;
                     st_nxt.st_cnt = '0;
                  end else begin
                     st_nxt.st_cnt = st_r.st_cnt + 9'h001;
                  end
               end
            end
            ST_HOLD: begin
               st_nxt.st = ST_HOLD;
            end
            default: begin
               st_nxt.st     = ST_IDLE;
               st_nxt.st_cnt = '0;
            end
         endcase
      end

      // Pin synchronisers
      st_nxt.link_s1 = phy_link;
      st_nxt.link_s2 = st_r.link_s1;
      st_nxt.act_s1  = phy_act;
      st_nxt.act_s2  = st_r.act_s1;

      // Lamp outputs
      st_nxt.mod_grn = sld_pat_grn(mod_pat, st_r.blink);
      st_nxt.mod_red = sld_pat_red(mod_pat, st_r.blink);
      st_nxt.net_grn = sld_pat_grn(net_pat, st_r.blink);
      st_nxt.net_red = sld_pat_red(net_pat, st_r.blink);
      st_nxt.link_on = st_r.link_s2;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Activity channels
   sld_act_flicker u_act0 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .ms_tick   (st_r.tick),
      .frame_evt (st_r.act_s2[0]),
      .act_lamp  (act_lamp[0])
   );

   sld_act_flicker u_act1 (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .ms_tick   (st_r.tick),
      .frame_evt (st_r.act_s2[1]),
      .act_lamp  (act_lamp[1])
   );

   // ==========================================================
   // Outputs
   assign module_health_lamp_grn  = st_r.mod_grn;
   assign module_health_lamp_red  = st_r.mod_red;
   assign network_health_lamp_grn = st_r.net_grn;
   assign network_health_lamp_red = st_r.net_red;
   assign link_lamp               = st_r.link_on;

   // ==========================================================
   // Checks
   AST_MOD_STEADY_GRN: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && !unrecov_fault && !recov_fault && configured)
      |=> (module_health_lamp_grn && !module_health_lamp_red))
      else $error("Module lamp not steady green while operating");

   AST_MOD_STANDBY: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && !unrecov_fault && !recov_fault && !configured)
      |=> (module_health_lamp_grn == $past(st_r.blink)) && !module_health_lamp_red)
      else $error("Module lamp not flashing green in standby");

   AST_MOD_RECOV: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && !unrecov_fault && recov_fault)
      |=> (module_health_lamp_red == $past(st_r.blink)) && !module_health_lamp_grn)
      else $error("Module lamp not flashing red on recoverable fault");

   AST_MOD_UNRECOV: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && unrecov_fault) |=> (module_health_lamp_red && !module_health_lamp_grn))
      else $error("Module lamp not steady red on unrecoverable fault");

   AST_SELFTEST_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(selftest_run) |=> ##1 (st_r.st == ST_GREEN) && module_health_lamp_grn && network_health_lamp_grn)
      else $error("Self-test did not open with green");

   AST_SELFTEST_RED: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (selftest_run && st_r.st == ST_RED) |=> (module_health_lamp_red && !module_health_lamp_grn))
      else $error("Module lamp not red in self-test red step");

   AST_SELFTEST_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (selftest_run && st_r.st == ST_GREEN && st_r.tick && st_r.st_cnt == STEP_LAST)
      |=> (st_r.st == ST_RED) && (st_r.st_cnt == 9'h000))
      else $error("Self-test green step length wrong");

   AST_SELFTEST_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (selftest_run && st_r.st == ST_HOLD)
      |=> (module_health_lamp_grn && !network_health_lamp_grn && !network_health_lamp_red))
      else $error("Self-test hold pattern wrong");

   AST_NET_CONNECTED: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && ip_valid && !dup_ip && eo_lost == 8'h00 && conn_present)
      |=> (network_health_lamp_grn && !network_health_lamp_red))
      else $error("Network lamp not steady green when connected");

   AST_NET_NOCONN: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && ip_valid && !dup_ip && eo_lost == 8'h00 && !conn_present)
      |=> (network_health_lamp_grn == $past(st_r.blink)) && !network_health_lamp_red)
      else $error("Network lamp not flashing green without connections");

   AST_NET_TIMEOUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && ip_valid && !dup_ip && eo_lost != 8'h00)
      |=> (network_health_lamp_red == $past(st_r.blink)) && !network_health_lamp_grn)
      else $error("Network lamp not flashing red on timeout");

   AST_NET_DUPIP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && ip_valid && dup_ip) |=> (network_health_lamp_red && !network_health_lamp_grn))
      else $error("Network lamp not steady red on duplicate address");

   AST_NET_NOIP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!selftest_run && !ip_valid) |=> (!network_health_lamp_grn && !network_health_lamp_red))
      else $error("Network lamp lit without address");

   AST_LINK: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!$past(sys_rst) && !$past(sys_rst, 2)) |=> (link_lamp == $past(phy_link, 3)))
      else $error("Link lamp does not follow link pin");

   AST_FLASH_PHASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_r.tick && st_r.blink_cnt == FLASH_LAST) |=> (st_r.blink != $past(st_r.blink)) && st_r.blink_cnt == 9'h000)
      else $error("Flash phase did not turn after 500 ticks");

   AST_TICK_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_r.pre == PRE_LAST) |=> (st_r.tick && st_r.pre == '0))
      else $error("Millisecond tick missing");

endmodule : sld_top

/* common/sld_pkg.sv */
// Package: timing constants, types and pattern decode for the status lamp driver
package sld_pkg;

   // ==========================================================
   // Time base
   localparam int unsigned CLK_PERIOD_NS    = 50;
   localparam int unsigned MS_NS            = 1000000;
   localparam int unsigned MS_TICK_CYC      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Pattern durations in milliseconds
   localparam int unsigned FLASH_HALF_MS    = 500;
   localparam int unsigned SELFTEST_STEP_MS = 250;
   localparam int unsigned FLICK_HALF_MS    = 50;

   localparam logic [8:0]  FLASH_LAST       = 9'(FLASH_HALF_MS - 1);
   localparam logic [8:0]  STEP_LAST        = 9'(SELFTEST_STEP_MS - 1);
   localparam logic [5:0]  FLICK_LAST       = 6'(FLICK_HALF_MS - 1);

   // ==========================================================
   // Reset values
   localparam logic        LAMP_RST         = 1'b0;
   localparam logic        BLINK_RST        = 1'b0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {ST_IDLE, ST_GREEN, ST_RED, ST_HOLD} sld_st_e;
   typedef enum logic [2:0] {PAT_OFF, PAT_GRN, PAT_RED, PAT_GRN_FLASH, PAT_RED_FLASH} sld_pat_e;

   // ==========================================================
   // Pattern decode
   function automatic logic sld_pat_grn(input sld_pat_e pat, input logic blink);
      return (pat == PAT_GRN) || ((pat == PAT_GRN_FLASH) && blink);
   endfunction : sld_pat_grn

   function automatic logic sld_pat_red(input sld_pat_e pat, input logic blink);
      return (pat == PAT_RED) || ((pat == PAT_RED_FLASH) && blink);
   endfunction : sld_pat_red

endpackage : sld_pkg

/* rtl/sld_act_flicker.sv */
// Module: per-channel activity lamp flicker generator
`timescale 1ns/1ps
module sld_act_flicker
   import sld_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic ms_tick,
   input  wire logic frame_evt,
   output logic      act_lamp
);

   // ==========================================================
   // State
   typedef struct packed {
      logic       lamp;
      logic       busy;
      logic       pend;
      logic [5:0] cnt;
   } sld_flk_s;

   sld_flk_s st_r;
   sld_flk_s st_nxt;

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (frame_evt) begin
         st_nxt.pend = 1'b1;
      end
      if (!st_r.busy) begin
         if (frame_evt) begin
            st_nxt.lamp = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.pend = 1'b0;
            st_nxt.cnt  = '0;
         end
      end else if (ms_tick) begin
         if (st_r.cnt == FLICK_LAST) begin
            st_nxt.cnt = '0;
            if (st_r.lamp) begin
               st_nxt.lamp = 1'b0;
            end else if (st_r.pend || frame_evt) begin
               st_nxt.lamp = 1'b1;
               st_nxt.pend = 1'b0;
            end else begin
               st_nxt.busy = 1'b0;
            end
         end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign act_lamp = st_r.lamp;

   AST_FLICK_LIT_HALF: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_r.busy && ms_tick && st_r.lamp && st_r.cnt != FLICK_LAST) |=> st_r.lamp)
      else $error("Activity lamp left lit phase early");

endmodule : sld_act_flicker

/* tb/sld_lamp_model.sv */
// Partner: front-panel duo lamp seen as a colour code
`timescale 1ns/1ps
module sld_lamp_model (
   input  wire logic  grn,
   input  wire logic  red,
   output logic [1:0] colour,
   output logic       clash
);
   // ==========================================================
   // Colour seen on the panel, red in bit 1
   assign colour = {red, grn};
   assign clash  = red & grn;
endmodule : sld_lamp_model

/* tb/sld_top_bench.sv */
// Testbench: status lamp driver against a behavioural lamp model
`timescale 1ns/1ps
module sld_top_bench;
   import sld_pkg::*;
   localparam int unsigned T = 4;
   logic       sys_clk       = 1'b0;
   logic       sys_rst       = 1'b1;
   logic       selftest_run  = 1'b0;
   logic       configured    = 1'b0;
   logic       recov_fault   = 1'b0;
   logic       unrecov_fault = 1'b0;
   logic       ip_valid      = 1'b0;
   logic       conn_present  = 1'b0;
   logic [7:0] eo_lost       = 8'h00;
   logic       dup_ip        = 1'b0;
   logic [1:0] phy_link      = 2'h0;
   logic [1:0] phy_act       = 2'h0;
   logic       mg, mr, ng, nr;
   logic [1:0] link_lamp, act_lamp, mod_col, net_col;
   logic       mod_clash, net_clash;
   int         n_mismatch    = 0;
   int         total_checks  = 0;
   int         seed          = 32'hE7E6E2E3;
   int         n;
   logic [31:0] r;

   // ==========================================================
   // Clock, design and panel lamps
   always #25 sys_clk = ~sys_clk;

   sld_top #(.TICK_CYC(T)) sld_top_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .selftest_run(selftest_run), .configured(configured),
      .recov_fault(recov_fault), .unrecov_fault(unrecov_fault), .ip_valid(ip_valid),
      .conn_present(conn_present), .eo_lost(eo_lost), .dup_ip(dup_ip), .phy_link(phy_link),
      .phy_act(phy_act), .module_health_lamp_grn(mg), .module_health_lamp_red(mr),
      .network_health_lamp_grn(ng), .network_health_lamp_red(nr), .link_lamp(link_lamp),
      .act_lamp(act_lamp));
   sld_lamp_model sld_lamp_model_i (.grn(mg), .red(mr), .colour(mod_col), .clash(mod_clash));
   sld_lamp_model sld_net_lamp_i (.grn(ng), .red(nr), .colour(net_col), .clash(net_clash));

   // ==========================================================
   // Behavioural model: 0 off, 1 green, 2 red, 3 green flash, 4 red flash
   function automatic int mod_exp();
      if (unrecov_fault) return 2;
      if (recov_fault) return 4;
      if (!configured) return 3;
      return 1;
   endfunction : mod_exp

   function automatic int net_exp();
      if (!ip_valid) return 0;
      if (dup_ip) return 2;
      if (eo_lost != 8'h00) return 4;
      if (conn_present) return 1;
      return 3;
   endfunction : net_exp

   // ==========================================================
   // Checking helpers
   task automatic check(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD t=%0t %s", $time, what);
      end
   endtask : check

   task automatic chk_duo(input int code, input logic [1:0] col, input string what);
      if (code < 3) check(col === 2'(code), what);
      else if (code == 3) check(col === 2'b00 || col === 2'b01, what);
      else check(col === 2'b00 || col === 2'b10, what);
   endtask : chk_duo

   task automatic wait_cyc(input int unsigned k);
      repeat (k) @(negedge sys_clk);
   endtask : wait_cyc

   function automatic logic pick(input int sel);
      case (sel)
         0:       return mg;
         1:       return act_lamp[0];
         default: return act_lamp[1];
      endcase
   endfunction : pick

   task automatic span(input int sel, input logic lvl, input int lim, output int k);
      k = 0;
      while (pick(sel) !== lvl && k < lim) begin
         @(negedge sys_clk);
         k++;
      end
   endtask : span

   task automatic all_dark(input string what);
      check({mg, mr, ng, nr, link_lamp, act_lamp} === 8'h00, what);
   endtask : all_dark

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   // ==========================================================
   // Watchdog
   initial begin
      #2000000;
      n_mismatch++;
      $display("BAD t=%0t watchdog expired", $time);
      complete_run();
   end

   // ==========================================================
   // Test sequence
   initial begin
      phy_link = 2'b11;
      phy_act  = 2'b11;
      wait_cyc(3);
      all_dark("lamps lit in reset");
      sys_rst = 1'b0;
      phy_act = 2'b00;
      $display("test reset done");

      unrecov_fault = 1'b1;
      selftest_run  = 1'b1;
      wait_cyc(125 * T);
      chk_duo(1, mod_col, "self-test module first step");
      chk_duo(1, net_col, "self-test network first step");
      wait_cyc(250 * T);
      chk_duo(2, mod_col, "self-test module second step");
      chk_duo(2, net_col, "self-test network second step");
      wait_cyc(250 * T);
      chk_duo(1, mod_col, "self-test module hold");
      chk_duo(0, net_col, "self-test network hold");
      selftest_run = 1'b0;
      wait_cyc(3);
      chk_duo(mod_exp(), mod_col, "after self-test");
      $display("test self-test done");

      for (int i = 0; i < 48; i++) begin
         r             = $random(seed);
         configured    = r[0];
         recov_fault   = r[1] & r[2];
         unrecov_fault = r[3] & r[4] & r[5];
         ip_valid      = r[6] | r[7];
         conn_present  = r[8];
         dup_ip        = r[9] & r[10] & r[11];
         eo_lost       = (r[12] & r[13]) ? r[23:16] : 8'h00;
         phy_link      = r[15:14];
         wait_cyc(5);
         chk_duo(mod_exp(), mod_col, "module lamp pattern");
         chk_duo(net_exp(), net_col, "network lamp pattern");
         check(link_lamp === phy_link, "link lamp");
         check(!mod_clash && !net_clash, "both colours lit");
      end
      $display("test random status done");

      {ip_valid, conn_present, dup_ip, eo_lost} = {3'b110, 8'h05};
      for (int k = 0; k < 3; k++) begin
         wait_cyc(5);
         chk_duo(net_exp(), net_col, "timeout recovery");
         eo_lost = eo_lost & ~(8'h01 << (2 * k));
      end
      $display("test timeout recovery done");

      {configured, recov_fault, unrecov_fault} = 3'b000;
      wait_cyc(2);
      span(0, 0, 1100 * T, n);
      span(0, 1, 1100 * T, n);
      span(0, 0, 1100 * T, n);
      check(n == 500 * T, "flash lit length");
      span(0, 1, 1100 * T, n);
      check(n == 500 * T, "flash dark length");
      $display("test flash timing done");

      phy_act = 2'b01;
      span(1, 1, 10, n);
      check(n <= 6, "activity lamp late");
      span(1, 0, 60 * T, n);
      span(1, 1, 60 * T, n);
      check(n >= 49 * T && n <= 51 * T, "flicker dark length");
      span(1, 0, 60 * T, n);
      check(n >= 49 * T && n <= 51 * T, "flicker lit length");
      check(act_lamp[1] === 1'b0, "idle channel lit");
      phy_act = 2'b00;
      wait_cyc(200 * T);
      check(act_lamp === 2'b00, "activity lamp after traffic");
      phy_act = 2'b10;
      wait_cyc(1);
      phy_act = 2'b00;
      span(2, 1, 10, n);
      check(n <= 6, "single frame not shown");
      span(2, 0, 60 * T, n);
      check(n >= 49 * T && n <= 51 * T, "single frame lit length");
      wait_cyc(200 * T);
      check(act_lamp === 2'b00, "single frame relit");
      $display("test activity done");

      {configured, ip_valid, conn_present, eo_lost, phy_link} = {3'b111, 8'h00, 2'b11};
      wait_cyc(5);
      chk_duo(1, net_col, "connected");
      sys_rst = 1'b1;
      wait_cyc(1);
      all_dark("lamps lit in second reset");
      sys_rst = 1'b0;
      wait_cyc(5);
      chk_duo(mod_exp(), mod_col, "module after second reset");
      $display("test second reset done");
      complete_run();
   end
endmodule : sld_top_bench
